/* File: hdl/jtag_bridge_defs.svh */
`ifndef JTAG_BRIDGE_DEFS_SVH
`define JTAG_BRIDGE_DEFS_SVH

// Data bus bit positions, shared by write capture and readback
`define BIT_TDI       0
`define BIT_TMS       1
`define BIT_TCK       2
`define BIT_TDO       3

// Reset values of the chain drive registers
`define RST_TDI       1'b0
`define RST_TMS       1'b1
`define RST_TCK       1'b0

// Default chain address on the processor bus
`define CHAIN_ADDR    8'h00

`endif

/* File: hdl/jtag_bridge_pkg.sv */
package jtag_bridge_pkg;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} chain_drive_t;

	typedef enum logic {
		SRC_CPU,
		SRC_CABLE
	} chain_src_t;

endpackage

/* File: hdl/sync2.sv */
`timescale 1ns/1ps

module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

/* File: hdl/bus_to_jtag_bridge.sv */
`timescale 1ns/1ps
`include "jtag_bridge_defs.svh"

// Functional notes
// - Only one decoded bus address reaches the chain.
// - TMS, TCK and TDI outputs come from registers on the system clock.
// - A cable select lets the download header drive the chain instead.
// - Data bus is required; address, strobe and direction are optional uses.
// - Decoded write captures data bits into three chain drive registers.
// - Data bus drivers enable only on a decoded read.
// - Reads return the three drive registers alongside TDO.
module bus_to_jtag_bridge
	import jtag_bridge_pkg::*;
#(
	parameter int         AW        = 8,
	parameter logic [7:0] CHAIN_ADR = `CHAIN_ADDR
) (
	// Clock and reset
	input  wire logic                       CLK_SYS,
	input  wire logic                       RST_N,
	// Processor bus
	input  wire logic [AW-1:0]              ADDR,
	input  wire logic                       ADDRESS_STROBE,
	input  wire logic                       READ_NOT_WRITE,
	input  wire logic [3:0]                 DATA_IN,
	output logic      [3:0]                 DATA_OUT,
	output logic                            DATA_OE,
	// Download cable header
	input  wire logic                       CABLE_SEL,
	input  wire jtag_bridge_pkg::chain_drive_t CABLE_DRV,
	output logic                            CABLE_TDO,
	// Chain
	input  wire logic                       CHAIN_TDO,
	output jtag_bridge_pkg::chain_drive_t   CHAIN_DRV
);

	import jtag_bridge_pkg::*;

	chain_drive_t drv_q;
	chain_src_t   src;
	logic [3:0]   sync_in;
	logic [3:0]   sync_out;
	logic         hit;
	logic         wr_hit;
	logic         rd_hit;

	// Cable and chain pins are asynchronous to the system clock
	assign sync_in = {CABLE_SEL, CABLE_DRV.tck ^ 1'b0, CABLE_DRV.tms, CABLE_DRV.tdi};

	sync2 #(.WIDTH(4)) u_sync_cable (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.d     (sync_in),
		.q     (sync_out)
	);

	// Readback of TDO trails the pin by two clocks, the price of a clean synchroniser
	logic tdo_meta_q;
	logic tdo_q;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			tdo_meta_q <= 1'b0;
			tdo_q      <= 1'b0;
		end else begin
			tdo_meta_q <= CHAIN_TDO;
			tdo_q      <= tdo_meta_q;
		end
	end

	// Bus inputs come from the processor logic on the same clock
	assign hit    = ADDRESS_STROBE && (ADDR == CHAIN_ADR[AW-1:0]);
	assign wr_hit = hit && !READ_NOT_WRITE;
	assign rd_hit = hit && READ_NOT_WRITE;
	assign src    = sync_out[3] ? SRC_CABLE : SRC_CPU;

	// Drive registers only change when software writes, so TCK edges are software paced while the CPU source drives the chain
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			drv_q.tdi <= `RST_TDI;
			drv_q.tms <= `RST_TMS;
			drv_q.tck <= `RST_TCK;
		end else if (wr_hit) begin
			drv_q.tdi <= DATA_IN[`BIT_TDI];
			drv_q.tms <= DATA_IN[`BIT_TMS];
			drv_q.tck <= DATA_IN[`BIT_TCK];
		end
	end

	// Output mux is registered, adding one cycle but keeping the pins glitch free
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			CHAIN_DRV.tdi <= `RST_TDI;
			CHAIN_DRV.tms <= `RST_TMS;
			CHAIN_DRV.tck <= `RST_TCK;
		end else if (src == SRC_CABLE) begin
			CHAIN_DRV.tdi <= sync_out[0];
			CHAIN_DRV.tms <= sync_out[1];
			CHAIN_DRV.tck <= sync_out[2];
		end else begin
			CHAIN_DRV <= drv_q;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			CABLE_TDO <= 1'b0;
		end else begin
			CABLE_TDO <= tdo_q;
		end
	end

	// Read data: only the optional bus signals gate it, the data bus itself is mandatory
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			DATA_OE  <= 1'b0;
			DATA_OUT <= 4'h0;
		end else begin
			DATA_OE <= rd_hit;
			if (rd_hit) begin
				DATA_OUT[`BIT_TDO] <= tdo_q;
				DATA_OUT[`BIT_TDI] <= drv_q.tdi;
				DATA_OUT[`BIT_TMS] <= drv_q.tms;
				DATA_OUT[`BIT_TCK] <= drv_q.tck;
			end else begin
				DATA_OUT <= 4'h0;
			end
		end
	end

	a_write_capture: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		wr_hit |=> (drv_q.tck == $past(DATA_IN[`BIT_TCK])
			&& drv_q.tms == $past(DATA_IN[`BIT_TMS])
			&& drv_q.tdi == $past(DATA_IN[`BIT_TDI])))
		else $error("write not captured");

	a_hold_nowrite: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		!wr_hit |=> $stable(drv_q))
		else $error("drive changed without write");

	a_oe_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		$past(RST_N) |-> DATA_OE == $past(rd_hit))
		else $error("bus enable not tied to read");

	a_readback_reg: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		rd_hit |=> (DATA_OUT[`BIT_TMS] == $past(drv_q.tms)
			&& DATA_OUT[`BIT_TCK] == $past(drv_q.tck)
			&& DATA_OUT[`BIT_TDI] == $past(drv_q.tdi)))
		else $error("readback mismatch");

	a_readback_tdo: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		rd_hit |=> DATA_OUT[`BIT_TDO] == $past(tdo_q))
		else $error("tdo not returned");

	a_cpu_drive: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(src == SRC_CPU) |=> CHAIN_DRV == $past(drv_q))
		else $error("chain not driven by registers");

	a_cable_drive: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(src == SRC_CABLE) |=> CHAIN_DRV == $past(sync_out[2:0]))
		else $error("cable not driving chain");

	a_other_addr: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(ADDRESS_STROBE && ADDR != CHAIN_ADR[AW-1:0]) |=> (!DATA_OE && $stable(drv_q)))
		else $error("foreign address decoded");

	a_oe_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		!rd_hit |=> (!DATA_OE && DATA_OUT == 4'h0))
		else $error("bus driven outside a read");

	a_strobe_low: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		!ADDRESS_STROBE |=> (!DATA_OE && $stable(drv_q)))
		else $error("access without strobe");

	a_read_keeps: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		rd_hit |=> $stable(drv_q))
		else $error("read disturbed drive registers");

	a_reset_state: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		$rose(RST_N) |-> (CHAIN_DRV.tck == `RST_TCK
			&& CHAIN_DRV.tms == `RST_TMS && !DATA_OE))
		else $error("chain not parked after reset");

	a_pins_quiet: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(src == SRC_CPU && $past(src) == SRC_CPU && $past(!wr_hit)) |=> $stable(CHAIN_DRV))
		else $error("chain pins moved without a write");

	a_cpu_write_pins: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(wr_hit && src == SRC_CPU) ##1 (src == SRC_CPU)
			|=> (CHAIN_DRV.tck == $past(DATA_IN[`BIT_TCK], 2)
			&& CHAIN_DRV.tdi == $past(DATA_IN[`BIT_TDI], 2)))
		else $error("write did not reach chain pins");

	a_tdo_sync: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		($past(RST_N) && $past(RST_N, 2)) |-> tdo_q == $past(CHAIN_TDO, 2))
		else $error("chain output not synchronised");

	a_sel_sync: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		($past(RST_N) && $past(RST_N, 2)) |-> ((src == SRC_CABLE) == $past(CABLE_SEL, 2)))
		else $error("cable select not synchronised");

	a_tdo_cable: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		$past(RST_N) |-> CABLE_TDO == $past(tdo_q))
		else $error("cable header lost chain output");

endmodule

/* File: testbench/chain_model.sv */
`timescale 1ns/1ps
module chain_model
	import jtag_bridge_pkg::*;
(
	input  wire logic         rst_n,
	input  wire chain_drive_t drv,
	output logic              tdo
);
	// One-bit bypass stage, so every rising test clock edge the bus makes is seen on TDO
	always_ff @(posedge drv.tck or negedge rst_n) begin
		if (!rst_n)
			tdo <= 1'b1;
		else
			tdo <= drv.tdi;
	end
endmodule

/* File: testbench/test_bus_to_jtag_bridge.sv */
`timescale 1ns/1ps
module test_bus_to_jtag_bridge;
	import jtag_bridge_pkg::*;
	logic         clk = 0, rst_n, as = 0, rnw = 0, sel = 0, tdo, oe, ctdo;
	logic [7:0]   adr = 0;
	logic [3:0]   din = 0, dout;
	logic [31:0]  lf = 32'h9f818122;
	chain_drive_t cdrv = '0, drv;
	int           errors = 0, tests_run = 0, mdl = 2, i;
	always #50 clk = ~clk;
	bus_to_jtag_bridge dut (.CLK_SYS(clk), .RST_N(rst_n), .ADDR(adr), .ADDRESS_STROBE(as),
		.READ_NOT_WRITE(rnw), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe),
		.CABLE_SEL(sel), .CABLE_DRV(cdrv), .CABLE_TDO(ctdo), .CHAIN_TDO(tdo), .CHAIN_DRV(drv));
	chain_model far (.rst_n(rst_n), .drv(drv), .tdo(tdo));
	function automatic logic [31:0] nx(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(string n, logic [3:0] e, logic [3:0] s);
		tests_run++;
		if (e !== s) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// One bus cycle; idle gap lets TDO settle through the synchronisers
	task automatic acc(logic r, logic [7:0] a, logic [3:0] d);
		@(negedge clk);
		as = 1;
		rnw = r;
		adr = a;
		din = d;
		@(negedge clk);
		as = 0;
		if (r) begin
			chk("oe", {3'b0, a == 0}, {3'b0, oe});
			chk("rdata", a == 0 ? {tdo, mdl[2:0]} : 4'h0, dout);
		end else if (a == 0)
			mdl = d[2:0];
		repeat (4) @(negedge clk);
		chk("drive", {1'b0, mdl[2:0]}, {1'b0, drv});
		chk("idle_data", 4'h0, dout);
		chk("idle_oe", 4'h0, {3'b0, oe});
	endtask
	task automatic print_verdict;
		if (errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		rst_n = 0;
		repeat (8) @(negedge clk);
		rst_n = 1;
		chk("reset", 4'h2, {1'b0, drv});
		chk("reset_bus", 4'h0, {2'b0, ctdo, oe});
		chk("reset_data", 4'h0, dout);
		// Synchronised TDO needs two edges before a read can see the pin
		repeat (2) @(negedge clk);
		for (i = 0; i < 40; i++) begin
			lf = nx(lf);
			acc(lf[4], {7'h0, lf[5] & lf[6]}, lf[3:0]);
		end
		acc(0, 8'h00, 4'h1);
		acc(0, 8'h00, 4'h5);
		chk("tck_edge", 4'h1, {3'b0, tdo});
		acc(1, 8'h00, 4'h0);
		acc(0, 8'h00, 4'h0);
		acc(0, 8'h00, 4'h4);
		chk("tck_edge", 4'h0, {3'b0, tdo});
		acc(1, 8'h00, 4'h0);
		@(negedge clk);
		rst_n = 0;
		#1;
		chk("reset_mid", 4'h2, {1'b0, drv});
		chk("reset_mid_bus", 4'h0, {2'b0, ctdo, oe});
		chk("reset_mid_data", 4'h0, dout);
		repeat (2) @(negedge clk);
		rst_n = 1;
		mdl = 2;
		repeat (2) @(negedge clk);
		acc(1, 8'h00, 4'h0);
		sel = 1;
		for (i = 0; i < 8; i++) begin
			lf = nx(lf);
			@(negedge clk);
			cdrv = chain_drive_t'(lf[2:0]);
			as = 1;
			rnw = 0;
			adr = 8'h00;
			din = lf[7:4];
			mdl = lf[6:4];
			@(negedge clk);
			as = 0;
			repeat (6) @(negedge clk);
			chk("cable", {1'b0, cdrv}, {1'b0, drv});
			chk("cable_tdo", {3'b0, tdo}, {3'b0, ctdo});
		end
		sel = 0;
		repeat (4) @(negedge clk);
		chk("cpu_back", {1'b0, mdl[2:0]}, {1'b0, drv});
		acc(1, 8'h00, 4'h0);
		print_verdict();
	end
	initial begin
		#300000;
		errors++;
		print_verdict();
	end
endmodule
